// ===== bench/swpecr_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module swpecr_regs_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        is_downstream,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [6:0]  acs_enable,
  input wire logic [7:0]  egress_vector,
  input wire logic [9:0]  snoop_value,
  input wire logic [2:0]  snoop_scale,
  input wire logic [9:0]  nosnoop_value,
  input wire logic [2:0]  nosnoop_scale
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence rd_at(a); rd && addr == a; endsequence
  chk_idle_rdata: assert property (!rd |=> rdata == 32'h0000_0000) else $error("rdata not zero");
  chk_l1ss_head: assert property (rd_at(12'h240) |=> rdata == 32'h0001_001E) else $error("l1ss header");
  chk_ltr_head: assert property (rd && addr == 12'h230 && !is_downstream |=> rdata == 32'h2401_0018)
    else $error("ltr header");
  chk_acs_read: assert property (rd && addr == 12'h224 && is_downstream
    |=> rdata == {9'h000, $past(acs_enable), 16'h087F}) else $error("acs readback");
  chk_acs_write: assert property (wr && addr == 12'h224 && is_downstream
    |=> acs_enable == $past(wdata[22:16])) else $error("acs enables");
  chk_egress_hold: assert property (!(wr && addr == 12'h228 && is_downstream) |=> $stable(egress_vector))
    else $error("egress changed");
  chk_lat_write: assert property (wr && addr == 12'h234 && !is_downstream |=>
    {nosnoop_scale, nosnoop_value, snoop_scale, snoop_value} == {$past(wdata[28:16]), $past(wdata[12:0])})
    else $error("latency fields");
  chk_role_absent: assert property (is_downstream ? {snoop_value, nosnoop_value} == 20'h0_0000
    : acs_enable == 7'h00 && egress_vector == 8'h00) else $error("absent register changed");
endmodule : swpecr_regs_chk
bind swpecr_regs swpecr_regs_chk u_chk (.clk, .reset, .is_downstream, .addr, .wdata, .wr, .rd, .rdata,
  .acs_enable, .egress_vector, .snoop_value, .snoop_scale, .nosnoop_value, .nosnoop_scale);
`default_nettype wire

// ===== bench/test_switch_port_ext_cap_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_switch_port_ext_cap_regs;
  logic        clk = 0, reset, is_downstream, wr = 0, rd = 0;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [6:0]  acs_enable;
  logic [7:0]  egress_vector;
  logic [9:0]  snoop_value, nosnoop_value;
  logic [2:0]  snoop_scale, nosnoop_scale;
  int          errors = 0, compares = 0;
  always #50 clk = ~clk;
  swpecr_regs uut (.clk, .reset, .is_downstream, .addr, .wdata, .wr, .rd, .rdata, .acs_enable, .egress_vector,
    .snoop_value, .snoop_scale, .nosnoop_value, .nosnoop_scale);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Leaves wr high so that writes may follow each other with no gap.
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
    @(posedge clk);
  endtask : rd_chk
  // The role strap only changes under reset, since it passes through a two-flop synchroniser.
  task automatic do_reset(input logic ds);
    reset <= 1'b1;
    is_downstream <= ds;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset
  task automatic final_report;
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    do_reset(1'b1);
    rd_chk(12'h220, 32'h2401_000D);
    rd_chk(12'h224, 32'h0000_087F);
    rd_chk(12'h228, 32'h0000_0000);
    rd_chk(12'h230, 32'h0000_0000);
    rd_chk(12'h300, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      wr_reg(12'h224, 32'hFF80_FFFF | (32'h1 << (16 + i)));
      rd_chk(12'h224, 32'h0000_087F | (32'h1 << (16 + i)));
      chk({25'h0, acs_enable}, 32'h1 << i);
    end
    wr_reg(12'h228, 32'hFFFF_FFFF);
    wr_reg(12'h234, 32'hFFFF_FFFF);
    rd_chk(12'h228, 32'h0000_00FF);
    chk({24'h0, egress_vector}, 32'h0000_00FF);
    rd_chk(12'h234, 32'h0000_0000);
    do_reset(1'b0);
    chk({24'h0, egress_vector}, 32'h0000_0000);
    chk({25'h0, acs_enable}, 32'h0000_0000);
    rd_chk(12'h230, 32'h2401_0018);
    rd_chk(12'h224, 32'h0000_0000);
    rd_chk(12'h240, 32'h0001_001E);
    wr_reg(12'h228, 32'hFFFF_FFFF);
    wr_reg(12'h234, 32'hA5A5_5A5A);
    rd_chk(12'h234, 32'h05A5_1A5A);
    chk({3'h0, nosnoop_scale, nosnoop_value, 3'h0, snoop_scale, snoop_value}, 32'h05A5_1A5A);
    rd_chk(12'h228, 32'h0000_0000);
    chk({24'h0, egress_vector}, 32'h0000_0000);
    final_report();
  end
endmodule : test_switch_port_ext_cap_regs
`default_nettype wire

// ===== rtl/swpecr_map.svh
`ifndef SWPECR_MAP_SVH
`define SWPECR_MAP_SVH

`define SWPECR_ADDR_W          12
`define SWPECR_OFF_ACS_HDR     12'h220
`define SWPECR_OFF_ACS_CAP     12'h224
`define SWPECR_OFF_EGRESS      12'h228
`define SWPECR_OFF_LTR_HDR     12'h230
`define SWPECR_OFF_LATENCY     12'h234
`define SWPECR_OFF_L1SS_HDR    12'h240

`define SWPECR_ACS_CAP_ID      16'h000D
`define SWPECR_LTR_CAP_ID      16'h0018
`define SWPECR_L1SS_CAP_ID     16'h001E
`define SWPECR_CAP_VER         4'h1
`define SWPECR_ACS_NEXT        12'h240
`define SWPECR_LTR_NEXT        12'h240
`define SWPECR_L1SS_NEXT       12'h000

`define SWPECR_ACS_FEATURES    7'h7F
`define SWPECR_EGRESS_SIZE     8'h08
`define SWPECR_ACS_EN_LSB      16
`define SWPECR_ACS_EN_W        7
`define SWPECR_ACS_EN_RESET    7'h00
`define SWPECR_EGRESS_RESET    8'h00
`define SWPECR_LAT_VAL_W       10
`define SWPECR_LAT_SCL_W       3
`define SWPECR_SNOOP_LSB       0
`define SWPECR_NOSNOOP_LSB     16
`define SWPECR_LAT_RESET       10'h000
`define SWPECR_SCL_RESET       3'h0

`endif

// ===== rtl/swpecr_pkg.sv
package swpecr_pkg;
  typedef enum logic [2:0] {
    swpecr_reg_none,
    swpecr_reg_acs_hdr,
    swpecr_reg_acs_cap,
    swpecr_reg_egress,
    swpecr_reg_ltr_hdr,
    swpecr_reg_latency,
    swpecr_reg_l1ss_hdr
  } swpecr_reg_t;
endpackage : swpecr_pkg

// ===== rtl/swpecr_regs.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "swpecr_map.svh"

// How it works
// (RL1) Capability bits 0..6 read as ones: all seven access-control features exist.
// (RL2) Bits 15:8 read-only egress vector size, reads eight.
// (RL3) Bit 16 read-write source check enable, reset zero.
// (RL4) Bit 17 read-write translation blocking enable, reset zero.
// (RL5) Bit 18 read-write request redirect enable, reset zero.
// (RL6) Bit 19 read-write completion redirect enable, reset zero.
// (RL7) Bit 20 read-write upstream forwarding enable, reset zero.
// (RL8) Bit 21 read-write egress control enable, reset zero.
// (RL9) Bit 22 read-write direct translated enable, reset zero.
// (RL10) Eight-bit read-write egress blocking vector in bits 7:0, reset zero.
// (RL11) Access-control registers exist only in downstream ports.
// (RL12) Latency-reporting header and latency word exist only in upstream port.
// (RL13) Latency header reads ID 0x0018, version one, next pointer 0x240.
// (RL14) Bits 9:0 read-write max snoop latency value, reset zero.
// (RL15) Bits 12:10 read-write snoop latency scale, reset zero.
// (RL16) Bits 25:16 read-write max no-snoop latency value, reset zero.
// (RL17) Bits 28:26 read-write no-snoop scale, reset zero; 31:29 reserved.
// (RL18) L1 substates header reads ID 0x001E, version one.
// (RL19) L1 substates next pointer reads zero, ending the chain.
// (RL20) Downstream access-control header reads ID 0x000D, version one.
// (RL21) Reserved bits and absent registers read zero and ignore writes.
module swpecr_regs
  import swpecr_pkg::*;
#(
  parameter int ADDR_W = `SWPECR_ADDR_W
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          is_downstream,
  input  wire logic [ADDR_W-1:0]             addr,
  input  wire logic [31:0]                   wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output var  logic [31:0]                   rdata,
  output var  logic [`SWPECR_ACS_EN_W-1:0]   acs_enable,
  output var  logic [7:0]                    egress_vector,
  output var  logic [`SWPECR_LAT_VAL_W-1:0]  snoop_value,
  output var  logic [`SWPECR_LAT_SCL_W-1:0]  snoop_scale,
  output var  logic [`SWPECR_LAT_VAL_W-1:0]  nosnoop_value,
  output var  logic [`SWPECR_LAT_SCL_W-1:0]  nosnoop_scale
);

  // The port role is a strap; it is sampled through two flops and is
  // expected to stay fixed after reset.
  logic        role_meta;
  logic        role_down;
  swpecr_reg_t sel;
  logic [31:0] next_rdata;

  always_ff @(posedge clk) begin
    if (reset) begin
      role_meta <= 1'b0;
      role_down <= 1'b0;
    end else begin
      role_meta <= is_downstream;
      role_down <= role_meta;
    end
  end

  function automatic swpecr_reg_t decode(input logic [ADDR_W-1:0] a, input logic down);
    swpecr_reg_t r;
    r = swpecr_reg_none;
    case (a)
      `SWPECR_OFF_ACS_HDR:  r = down ? swpecr_reg_acs_hdr : swpecr_reg_none;   // see (RL11)
      `SWPECR_OFF_ACS_CAP:  r = down ? swpecr_reg_acs_cap : swpecr_reg_none;   // see (RL11)
      `SWPECR_OFF_EGRESS:   r = down ? swpecr_reg_egress : swpecr_reg_none;    // see (RL11)
      `SWPECR_OFF_LTR_HDR:  r = down ? swpecr_reg_none : swpecr_reg_ltr_hdr;   // see (RL12)
      `SWPECR_OFF_LATENCY:  r = down ? swpecr_reg_none : swpecr_reg_latency;   // see (RL12)
      `SWPECR_OFF_L1SS_HDR: r = swpecr_reg_l1ss_hdr;
      default:              r = swpecr_reg_none;                               // see (RL21)
    endcase
    return r;
  endfunction : decode

  assign sel = decode(addr, role_down);

  always_ff @(posedge clk) begin
    if (reset) begin
      acs_enable <= `SWPECR_ACS_EN_RESET;                                      // see (RL3)
    end else if (wr && sel == swpecr_reg_acs_cap) begin
      // Bits 16..22 in order: source, translation, request, completion,
      // upstream, egress, direct translated.
      acs_enable <= wdata[`SWPECR_ACS_EN_LSB +: `SWPECR_ACS_EN_W];             // see (RL4) (RL5) (RL6) (RL7) (RL8) (RL9)
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      egress_vector <= `SWPECR_EGRESS_RESET;
    end else if (wr && sel == swpecr_reg_egress) begin
      egress_vector <= wdata[7:0];                                             // see (RL10)
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      snoop_value   <= `SWPECR_LAT_RESET;
      snoop_scale   <= `SWPECR_SCL_RESET;
      nosnoop_value <= `SWPECR_LAT_RESET;
      nosnoop_scale <= `SWPECR_SCL_RESET;
    end else if (wr && sel == swpecr_reg_latency) begin
      snoop_value   <= wdata[`SWPECR_SNOOP_LSB +: `SWPECR_LAT_VAL_W];          // see (RL14)
      snoop_scale   <= wdata[`SWPECR_SNOOP_LSB + `SWPECR_LAT_VAL_W +: `SWPECR_LAT_SCL_W];     // see (RL15)
      nosnoop_value <= wdata[`SWPECR_NOSNOOP_LSB +: `SWPECR_LAT_VAL_W];        // see (RL16)
      nosnoop_scale <= wdata[`SWPECR_NOSNOOP_LSB + `SWPECR_LAT_VAL_W +: `SWPECR_LAT_SCL_W];   // see (RL17)
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;                                                // see (RL21)
    case (sel)
      swpecr_reg_acs_hdr:  next_rdata = {`SWPECR_ACS_NEXT, `SWPECR_CAP_VER, `SWPECR_ACS_CAP_ID};     // see (RL20)
      swpecr_reg_acs_cap:  next_rdata = {9'h000, acs_enable, `SWPECR_EGRESS_SIZE, 1'b0,
                                         `SWPECR_ACS_FEATURES};                // see (RL1) (RL2)
      swpecr_reg_egress:   next_rdata = {24'h00_0000, egress_vector};
      swpecr_reg_ltr_hdr:  next_rdata = {`SWPECR_LTR_NEXT, `SWPECR_CAP_VER, `SWPECR_LTR_CAP_ID};     // see (RL13)
      swpecr_reg_latency:  next_rdata = {3'h0, nosnoop_scale, nosnoop_value,
                                         3'h0, snoop_scale, snoop_value};      // see (RL17)
      swpecr_reg_l1ss_hdr: next_rdata = {`SWPECR_L1SS_NEXT, `SWPECR_CAP_VER, `SWPECR_L1SS_CAP_ID};   // see (RL18) (RL19)
      default:             next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is held only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? next_rdata : 32'h0000_0000;
    end
  end

endmodule : swpecr_regs
`default_nettype wire
